//--- mrw_map.svh
`ifndef MRW_MAP_SVH
`define MRW_MAP_SVH

// ==========================================================
// Register map, byte addresses
`define MRW_AW            8
`define MRW_OFS_PROBE0    8'h00
`define MRW_OFS_TAG0      8'h10
`define MRW_OFS_COUNT     8'h28
`define MRW_NPROBE        3
`define MRW_NTAG          6

// ==========================================================
// Probe configuration fields
`define MRW_PORT_W        4
`define MRW_ENC_W         7
`define MRW_PORT_LSB      0
`define MRW_ENC_LSB       8
`define MRW_MODE_LSB      16
`define MRW_PROBE_RST     32'h0000_0000

// ==========================================================
// Tag configuration fields
`define MRW_VID_LSB       0
`define MRW_DEI_BIT       12
`define MRW_PCP_LSB       13
`define MRW_PSEL_LSB      16
`define MRW_TPID_LSB      18
`define MRW_TAG_RST       32'h0000_0001
`define MRW_TPID_0        16'h8100
`define MRW_TPID_1        16'h88A8
`define MRW_TPID_2        16'h9100
`define MRW_TPID_3        16'h9200

// ==========================================================
// Rewrite descriptor layout
`define MRW_DESC_W        80
`define MRW_D_TAG0        0
`define MRW_D_TAG1        32
`define MRW_D_ENC         64
`define MRW_D_AFTLL       71
`define MRW_D_TCNT        72
`define MRW_D_PORT        74
`define MRW_D_MIR         78
`define MRW_D_EDIT        79
`define MRW_FIFO_DEPTH    8

// ==========================================================
// Bus answers
`define MRW_RESP_OKAY     2'h0
`define MRW_RESP_SLVERR   2'h2

`endif

//--- mrw_pkg.sv
package mrw_pkg;

  // ==========================================================
  // Remote mirror mode of a probe
  typedef enum logic [1:0] {
    MRW_MODE_NONE,
    MRW_MODE_ONE_TAG,
    MRW_MODE_TWO_TAG,
    MRW_MODE_ENCAP
  } mrw_mode_t;

  typedef logic [31:0] mrw_word_t;

endpackage

//--- mrw_fifo.sv
module mrw_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = 8
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             CE,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  input  wire logic [WIDTH-1:0] IN_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY,
  output logic      [WIDTH-1:0] OUT_DATA
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             ready_reg;
  wire              push = IN_VALID && ready_reg;
  wire              pop  = OUT_VALID && OUT_READY;

  // Ready comes from a flop so that upstream sees no combinational path
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign IN_READY   = ready_reg;
  assign OUT_VALID  = count_reg != '0;
  assign OUT_DATA   = mem[rp_reg];

  always_ff @(posedge CLK) begin
    if (CE && push) begin
      mem[wp_reg] <= IN_DATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wp_reg    <= '0;
      rp_reg    <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
    end else if (CE) begin
      wp_reg    <= push ? wp_reg + 1'b1 : wp_reg;
      rp_reg    <= pop ? rp_reg + 1'b1 : rp_reg;
      count_reg <= count_next;
      ready_reg <= count_next < (AW+1)'(DEPTH);
    end
  end

endmodule

//--- mrw_rewriter.sv
// Notes on behaviour
// - Three probe sets, each with own port, tagging and encapsulation settings
// - Mirror status comes only from the frame header fields
// - Probe index 0 means no mirror; 1 to 3 select probe set
// - Header flag 1 marks an ingress copy, 0 an egress copy
// - Egress copies get the same edits as the probe port copy
// - Egress copy rewrite port comes from the probe's transmit-port field
// - Ingress copies leave unmodified
// - Mode selects none, one tag, two tags or encapsulation entry
// - Enabled remote tags go onto every copy of that probe
// - Tags follow outer source MAC, or link-layer source MAC if added
// - Each tag built from priority, priority source, DEI, VID, TPID select
// - Encapsulation mode uses the probe's remote encapsulation index
// - Probe encapsulation index replaces the egress rule lookup choice
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`include "mrw_map.svh"
module mrw_rewriter
  import mrw_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic                   CE,
  input  wire logic                   AWVALID,
  output logic                        AWREADY,
  input  wire logic [`MRW_AW-1:0]     AWADDR,
  input  wire logic                   WVALID,
  output logic                        WREADY,
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  output logic                        BVALID,
  input  wire logic                   BREADY,
  output logic [1:0]                  BRESP,
  input  wire logic                   ARVALID,
  output logic                        ARREADY,
  input  wire logic [`MRW_AW-1:0]     ARADDR,
  output logic                        RVALID,
  input  wire logic                   RREADY,
  output logic [31:0]                 RDATA,
  output logic [1:0]                  RRESP,
  input  wire logic                   IN_VALID,
  output logic                        IN_READY,
  input  wire logic [1:0]             IN_PROBE,
  input  wire logic                   IN_RX_MIRROR,
  input  wire logic [`MRW_PORT_W-1:0] IN_TX_PORT,
  input  wire logic [`MRW_ENC_W-1:0]  IN_ENCAP,
  input  wire logic [2:0]             IN_CLS_PCP,
  output logic                        OUT_VALID,
  input  wire logic                   OUT_READY,
  output logic                        OUT_EDIT,
  output logic                        OUT_MIRROR,
  output logic [`MRW_PORT_W-1:0]      OUT_PORT,
  output logic [1:0]                  OUT_TAG_CNT,
  output logic                        OUT_TAG_AFTER_LL,
  output logic [`MRW_ENC_W-1:0]       OUT_ENCAP,
  output logic [31:0]                 OUT_TAG0,
  output logic [31:0]                 OUT_TAG1
);

  // ==========================================================
  // Configuration and status storage
  mrw_word_t probe_cfg_reg [0:`MRW_NPROBE-1];
  mrw_word_t tag_cfg_reg   [0:`MRW_NTAG-1];
  mrw_word_t count_reg;

  // ==========================================================
  // Register bus: write channel
  logic                 awready_reg;
  logic                 wready_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  logic                 aw_got_reg;
  logic                 w_got_reg;
  logic [`MRW_AW-1:0]   aw_addr_reg;
  mrw_word_t            w_data_reg;
  logic [3:0]           w_strb_reg;
  wire                  aw_take = AWVALID && awready_reg;
  wire                  w_take  = WVALID && wready_reg;
  wire                  b_done  = bvalid_reg && BREADY;
  wire                  wr_do   = aw_got_reg && w_got_reg && !bvalid_reg;
  wire [5:0]            wr_word = aw_addr_reg[`MRW_AW-1:2];
  wire [5:0]            probe_w = 6'(`MRW_OFS_PROBE0 >> 2);
  wire [5:0]            tag_w   = 6'(`MRW_OFS_TAG0 >> 2);
  wire [5:0]            count_w = 6'(`MRW_OFS_COUNT >> 2);
  wire                  wr_probe = wr_word - probe_w < 6'(`MRW_NPROBE);
  wire                  wr_tag   = wr_word - tag_w < 6'(`MRW_NTAG);
  wire [5:0]            wr_tidx  = wr_word - tag_w;
  wire [5:0]            wr_pidx  = wr_word - probe_w;
  mrw_word_t            wmask;

  // Byte lanes follow the write strobes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{w_strb_reg[b]}};
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `MRW_RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else if (CE) begin
      if (aw_take) begin
        awready_reg <= 1'b0;
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= AWADDR;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        w_got_reg  <= 1'b1;
        w_data_reg <= WDATA;
        w_strb_reg <= WSTRB;
      end
      if (wr_do) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wr_probe || wr_tag) ? `MRW_RESP_OKAY
                                           : `MRW_RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Each probe keeps its own copy of every setting
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < `MRW_NPROBE; i++) begin
        probe_cfg_reg[i] <= `MRW_PROBE_RST;
      end
      for (int i = 0; i < `MRW_NTAG; i++) begin
        tag_cfg_reg[i] <= `MRW_TAG_RST;
      end
    end else if (CE && wr_do) begin
      for (int i = 0; i < `MRW_NPROBE; i++) begin
        if (wr_probe && wr_pidx == 6'(i)) begin
          probe_cfg_reg[i] <= (probe_cfg_reg[i] & ~wmask)
                              | (w_data_reg & wmask);
        end
      end
      for (int i = 0; i < `MRW_NTAG; i++) begin
        if (wr_tag && wr_tidx == 6'(i)) begin
          tag_cfg_reg[i] <= (tag_cfg_reg[i] & ~wmask)
                            | (w_data_reg & wmask);
        end
      end
    end
  end

  // ==========================================================
  // Register bus: read channel
  logic                 arready_reg;
  logic                 rvalid_reg;
  mrw_word_t            rdata_reg;
  logic [1:0]           rresp_reg;
  wire                  ar_take = ARVALID && arready_reg;
  wire [5:0]            rd_word = ARADDR[`MRW_AW-1:2];
  wire [5:0]            rd_pidx = rd_word - probe_w;
  wire [5:0]            rd_tidx = rd_word - tag_w;
  wire                  rd_probe = rd_pidx < 6'(`MRW_NPROBE);
  wire                  rd_tag   = rd_tidx < 6'(`MRW_NTAG);
  wire                  rd_count = rd_word == count_w;
  wire                  rd_ok    = rd_probe || rd_tag || rd_count;
  wire mrw_word_t       rd_data  =
    rd_probe ? probe_cfg_reg[rd_pidx[1:0]] :
    rd_tag   ? tag_cfg_reg[rd_tidx[2:0]]   :
    rd_count ? count_reg : 32'h0000_0000;

  always_ff @(posedge CLK) begin
    if (RST) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= `MRW_RESP_OKAY;
    end else if (CE) begin
      if (ar_take) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_data;
        rresp_reg   <= rd_ok ? `MRW_RESP_OKAY : `MRW_RESP_SLVERR;
      end else if (rvalid_reg && RREADY) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Header decode and descriptor build
  wire                  in_take = IN_VALID && IN_READY;
  wire                  is_mir  = IN_PROBE != 2'h0;
  wire                  is_rx   = is_mir && IN_RX_MIRROR;
  wire [1:0]            psel    = is_mir ? IN_PROBE - 2'h1 : 2'h0;
  wire mrw_word_t       pcfg    = probe_cfg_reg[psel];
  wire [`MRW_PORT_W-1:0] cfg_port =
    pcfg[`MRW_PORT_LSB +: `MRW_PORT_W];
  wire [`MRW_ENC_W-1:0] cfg_enc = pcfg[`MRW_ENC_LSB +: `MRW_ENC_W];
  wire mrw_mode_t       mode    = is_mir
    ? mrw_mode_t'(pcfg[`MRW_MODE_LSB +: 2]) : MRW_MODE_NONE;
  wire [1:0]            tag_cnt =
    mode == MRW_MODE_ONE_TAG ? 2'h1 :
    mode == MRW_MODE_TWO_TAG ? 2'h2 : 2'h0;
  // Encapsulation override replaces the egress rule lookup choice
  wire [`MRW_ENC_W-1:0] enc_out =
    mode == MRW_MODE_ENCAP ? cfg_enc :
    is_rx                  ? '0 : IN_ENCAP;
  // Egress copies are edited as for the probe port
  wire [`MRW_PORT_W-1:0] port_out =
    (is_mir && !is_rx) ? cfg_port : IN_TX_PORT;
  wire                  edit_out = !is_rx;
  // Tags sit after the link-layer source MAC when one is pushed
  wire                  aftll_out = tag_cnt != 2'h0 && enc_out != '0;
  mrw_word_t            tag_word [0:1];

  for (genvar t = 0; t < 2; t++) begin : g_tag
    wire mrw_word_t tcfg = tag_cfg_reg[{psel, 1'(t)}];
    wire [1:0]      tsel = tcfg[`MRW_TPID_LSB +: 2];
    wire [1:0]      psrc = tcfg[`MRW_PSEL_LSB +: 2];
    wire [2:0]      pcp  = psrc == 2'h1 ? IN_CLS_PCP
                                        : tcfg[`MRW_PCP_LSB +: 3];
    wire [15:0]     tpid = tsel == 2'h0 ? `MRW_TPID_0 :
                           tsel == 2'h1 ? `MRW_TPID_1 :
                           tsel == 2'h2 ? `MRW_TPID_2 : `MRW_TPID_3;
    assign tag_word[t] = {tpid, pcp, tcfg[`MRW_DEI_BIT],
                          tcfg[`MRW_VID_LSB +: 12]};
  end

  wire [`MRW_DESC_W-1:0] desc = {edit_out, is_mir, port_out, tag_cnt,
                                 aftll_out, enc_out,
                                 tag_word[1], tag_word[0]};

  always_ff @(posedge CLK) begin
    if (RST) begin
      count_reg <= '0;
    end else if (CE && in_take && is_mir) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Frame queue and output stage
  // One descriptor per cycle; a single queue keeps arrival order
  logic                  f_valid;
  logic [`MRW_DESC_W-1:0] f_data;
  logic                  out_valid_reg;
  logic [`MRW_DESC_W-1:0] out_desc_reg;
  wire                   out_free = !out_valid_reg || OUT_READY;

  mrw_fifo #(
    .WIDTH (`MRW_DESC_W),
    .DEPTH (`MRW_FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .RST       (RST),
    .CE        (CE),
    .IN_VALID  (IN_VALID),
    .IN_READY  (IN_READY),
    .IN_DATA   (desc),
    .OUT_VALID (f_valid),
    .OUT_READY (out_free),
    .OUT_DATA  (f_data)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      out_valid_reg <= 1'b0;
      out_desc_reg  <= '0;
    end else if (CE && out_free) begin
      out_valid_reg <= f_valid;
      if (f_valid) begin
        out_desc_reg <= f_data;
      end
    end
  end

  assign AWREADY          = awready_reg;
  assign WREADY           = wready_reg;
  assign BVALID           = bvalid_reg;
  assign BRESP            = bresp_reg;
  assign ARREADY          = arready_reg;
  assign RVALID           = rvalid_reg;
  assign RDATA            = rdata_reg;
  assign RRESP            = rresp_reg;
  assign OUT_VALID        = out_valid_reg;
  assign OUT_EDIT         = out_desc_reg[`MRW_D_EDIT];
  assign OUT_MIRROR       = out_desc_reg[`MRW_D_MIR];
  assign OUT_PORT         = out_desc_reg[`MRW_D_PORT +: `MRW_PORT_W];
  assign OUT_TAG_CNT      = out_desc_reg[`MRW_D_TCNT +: 2];
  assign OUT_TAG_AFTER_LL = out_desc_reg[`MRW_D_AFTLL];
  assign OUT_ENCAP        = out_desc_reg[`MRW_D_ENC +: `MRW_ENC_W];
  assign OUT_TAG0         = out_desc_reg[`MRW_D_TAG0 +: 32];
  assign OUT_TAG1         = out_desc_reg[`MRW_D_TAG1 +: 32];

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_out_stall;
    CE && OUT_VALID && !OUT_READY;
  endsequence

  sequence s_wr_pair;
    CE && aw_got_reg && w_got_reg && !bvalid_reg;
  endsequence

  a_probe_bypass: assert property (
    in_take && IN_PROBE == 2'h0 |-> desc[`MRW_D_TCNT +: 2] == 2'h0
      && desc[`MRW_D_ENC +: `MRW_ENC_W] == IN_ENCAP && desc[`MRW_D_EDIT])
    else $error("Non-mirror frame altered");

  a_rx_unmodified: assert property (
    in_take && IN_PROBE != 2'h0 && IN_RX_MIRROR |-> !desc[`MRW_D_EDIT])
    else $error("Ingress copy marked for edit");

  a_tx_port_sel: assert property (
    in_take && IN_PROBE != 2'h0 && !IN_RX_MIRROR |->
      desc[`MRW_D_PORT +: `MRW_PORT_W]
      == probe_cfg_reg[IN_PROBE - 2'h1][`MRW_PORT_LSB +: `MRW_PORT_W])
    else $error("Egress copy used wrong port");

  a_tag_count: assert property (
    in_take && IN_PROBE != 2'h0 |-> desc[`MRW_D_TCNT +: 2] ==
      (probe_cfg_reg[IN_PROBE - 2'h1][`MRW_MODE_LSB +: 2] == 2'h1 ? 2'h1 :
       probe_cfg_reg[IN_PROBE - 2'h1][`MRW_MODE_LSB +: 2] == 2'h2 ? 2'h2
       : 2'h0))
    else $error("Tag count mismatch");

  a_encap_override: assert property (
    in_take && IN_PROBE != 2'h0
      && probe_cfg_reg[IN_PROBE - 2'h1][`MRW_MODE_LSB +: 2] == 2'h3 |->
      desc[`MRW_D_ENC +: `MRW_ENC_W]
      == probe_cfg_reg[IN_PROBE - 2'h1][`MRW_ENC_LSB +: `MRW_ENC_W])
    else $error("Encapsulation index not overridden");

  a_out_hold: assert property (
    s_out_stall |=> OUT_VALID && $stable(out_desc_reg))
    else $error("Output changed while stalled");

  a_write_resp: assert property (
    s_wr_pair |=> BVALID ##0 !AWREADY && !WREADY)
    else $error("Write response missing");

  a_read_hold: assert property (
    CE && RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("Read data dropped");

  a_ce_freeze: assert property (
    !CE |=> $stable(out_desc_reg) && $stable(count_reg))
    else $error("State moved while disabled");

endmodule

//--- mrw_far_model.sv
`include "mrw_map.svh"
module mrw_far_model (
  input  wire logic        CLK,
  input  wire logic        IN_READY,
  output logic             IN_VALID,
  output logic [1:0]       IN_PROBE,
  output logic             IN_RX_MIRROR,
  output logic [3:0]       IN_TX_PORT,
  output logic [6:0]       IN_ENCAP,
  output logic [2:0]       IN_CLS_PCP,
  input  wire logic        OUT_VALID,
  output logic             OUT_READY,
  input  wire logic [79:0] OUT_DESC
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Frame source and egress queue sink
  logic [16:0] txq[$];
  logic [79:0] rxq[$];
  logic        stall;
  logic [16:0] cur;
  initial begin
    stall = 1'b0;
    IN_VALID = 1'b0;
    OUT_READY = 1'b1;
    {IN_PROBE, IN_RX_MIRROR, IN_TX_PORT, IN_ENCAP, IN_CLS_PCP} = '0;
  end
  // Header offers probe index and ingress flag; idle lines show inverse
  always @(posedge CLK) begin
    if (IN_VALID && IN_READY)
      void'(txq.pop_front());
    if (OUT_VALID && OUT_READY)
      rxq.push_back(OUT_DESC);
    OUT_READY <= !stall;
    IN_VALID <= (txq.size() != 0);
    cur = (txq.size() != 0) ? txq[0] :
          ~{IN_PROBE, IN_RX_MIRROR, IN_TX_PORT, IN_ENCAP, IN_CLS_PCP};
    {IN_PROBE, IN_RX_MIRROR, IN_TX_PORT, IN_ENCAP, IN_CLS_PCP} <= cur;
  end
endmodule

//--- mirror_frame_rewriter_tb.sv
`include "mrw_map.svh"
module mirror_frame_rewriter_tb
  import mrw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals and reference state
  logic        CLK, RST, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IN_READY;
  logic        IN_VALID, IN_RX_MIRROR, OUT_VALID, OUT_READY;
  logic        OUT_EDIT, OUT_MIRROR, OUT_TAG_AFTER_LL;
  logic [1:0]  BRESP, RRESP, IN_PROBE, OUT_TAG_CNT;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, OUT_TAG0, OUT_TAG1;
  logic [3:0]  WSTRB, IN_TX_PORT, OUT_PORT;
  logic [6:0]  IN_ENCAP, OUT_ENCAP;
  logic [2:0]  IN_CLS_PCP;
  logic [3:0]  pport[1:3];
  logic [6:0]  penc[1:3];
  logic [1:0]  pmode[1:3];
  logic [31:0] tcfg[1:3][0:1];
  logic [79:0] expq[$];
  int          errors, compares, nmir;

  mrw_rewriter dut (.CLK(CLK), .RST(RST), .CE(CE),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_PROBE(IN_PROBE),
    .IN_RX_MIRROR(IN_RX_MIRROR), .IN_TX_PORT(IN_TX_PORT),
    .IN_ENCAP(IN_ENCAP), .IN_CLS_PCP(IN_CLS_PCP),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_EDIT(OUT_EDIT),
    .OUT_MIRROR(OUT_MIRROR), .OUT_PORT(OUT_PORT),
    .OUT_TAG_CNT(OUT_TAG_CNT), .OUT_TAG_AFTER_LL(OUT_TAG_AFTER_LL),
    .OUT_ENCAP(OUT_ENCAP), .OUT_TAG0(OUT_TAG0), .OUT_TAG1(OUT_TAG1));

  mrw_far_model far (.CLK(CLK), .IN_READY(IN_READY),
    .IN_VALID(IN_VALID), .IN_PROBE(IN_PROBE),
    .IN_RX_MIRROR(IN_RX_MIRROR), .IN_TX_PORT(IN_TX_PORT),
    .IN_ENCAP(IN_ENCAP), .IN_CLS_PCP(IN_CLS_PCP),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .OUT_DESC({OUT_EDIT, OUT_MIRROR, OUT_PORT, OUT_TAG_CNT,
      OUT_TAG_AFTER_LL, OUT_ENCAP, OUT_TAG1, OUT_TAG0}));

  always #20 CLK = ~CLK;

  // ==========================================================
  // Compare, bus and reference helpers
  task automatic cmp_w(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t word exp %h got %h", $time, e, g);
    end
  endtask

  // Tags beyond the pushed count carry no meaning, so they are masked
  task automatic cmp_d(input logic [79:0] e, input logic [79:0] g);
    if (e[73:72] < 2'h2) {e[63:32], g[63:32]} = 64'h0;
    if (e[73:72] < 2'h1) {e[31:0], g[31:0]} = 64'h0;
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t desc exp %h got %h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge CLK);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= d;
    WSTRB <= 4'hF;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    BREADY <= 1'b0;
    cmp_w({30'h0, er}, {30'h0, BRESP});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge CLK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    RREADY <= 1'b0;
    cmp_w(ed, RDATA);
    cmp_w({30'h0, er}, {30'h0, RRESP});
  endtask

  function automatic logic [31:0] mk_tag(input logic [31:0] c,
                                         input logic [2:0] cls);
    logic [15:0] tp;
    case (c[19:18])
      2'h0: tp = `MRW_TPID_0;
      2'h1: tp = `MRW_TPID_1;
      2'h2: tp = `MRW_TPID_2;
      default: tp = `MRW_TPID_3;
    endcase
    return {tp, (c[17:16] == 2'h1) ? cls : c[15:13], c[12], c[11:0]};
  endfunction

  function automatic logic [79:0] mk_exp(input logic [16:0] f);
    logic [1:0]  p, n;
    logic        rx;
    logic [3:0]  pt;
    logic [6:0]  e;
    logic [31:0] t0, t1;
    {p, rx, pt, e} = f[16:3];
    if (p == 2'h0) return {2'h2, pt, 3'h0, e, 64'h0};
    n = (pmode[p] == MRW_MODE_ONE_TAG) ? 2'h1 :
        (pmode[p] == MRW_MODE_TWO_TAG) ? 2'h2 : 2'h0;
    if (pmode[p] == MRW_MODE_ENCAP) e = penc[p];
    else if (rx) e = 7'h0;
    t0 = mk_tag(tcfg[p][0], f[2:0]);
    t1 = mk_tag(tcfg[p][1], f[2:0]);
    return {!rx, 1'b1, rx ? pt : pport[p], n, (n != 0 && e != 0), e,
            t1, t0};
  endfunction

  task automatic frm(input int p, input logic rx, input logic [3:0] pt,
                     input logic [6:0] e, input logic [2:0] c);
    far.txq.push_back({2'(p), rx, pt, e, c});
    expq.push_back(mk_exp({2'(p), rx, pt, e, c}));
    if (p != 0) nmir++;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (far.rxq.size() < expq.size() && n < 500) begin
      @(posedge CLK);
      n++;
    end
    cmp_w(32'h1, 32'(n < 500));
    while (expq.size() != 0 && far.rxq.size() != 0)
      cmp_d(expq.pop_front(), far.rxq.pop_front());
    expq.delete();
  endtask

  task automatic set_probe(input int p, input logic [31:0] v);
    pport[p] = v[3:0];
    penc[p] = v[14:8];
    pmode[p] = v[17:16];
    wr(`MRW_OFS_PROBE0 + 8'(4 * (p - 1)), v, `MRW_RESP_OKAY);
    rd(`MRW_OFS_PROBE0 + 8'(4 * (p - 1)), v, `MRW_RESP_OKAY);
  endtask

  task automatic set_tag(input int p, input int t, input logic [31:0] v);
    tcfg[p][t] = v;
    wr(`MRW_OFS_TAG0 + 8'(8 * (p - 1) + 4 * t), v, `MRW_RESP_OKAY);
    rd(`MRW_OFS_TAG0 + 8'(8 * (p - 1) + 4 * t), v, `MRW_RESP_OKAY);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int p = 1; p <= 3; p++) begin
      rd(`MRW_OFS_PROBE0 + 8'(4 * (p - 1)), `MRW_PROBE_RST, 2'h0);
      for (int t = 0; t < 2; t++)
        rd(`MRW_OFS_TAG0 + 8'(8 * (p - 1) + 4 * t), `MRW_TAG_RST,
           2'h0);
    end
    rd(`MRW_OFS_COUNT, 32'h0, `MRW_RESP_OKAY);
    wr(`MRW_OFS_COUNT, 32'h5, `MRW_RESP_SLVERR);
    wr(8'h30, 32'h1, `MRW_RESP_SLVERR);
    rd(8'h30, 32'h0, `MRW_RESP_SLVERR);
    $display("test reset_regs done");
  endtask

  // Each mode on all probes; ports kept within normal expansion
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      for (int p = 1; p <= 3; p++) begin
        set_probe(p, {14'h0, 2'(m), 1'b0, 7'(16 * p + m + 1), 4'h0,
                      4'(p + 4 * m)});
        set_tag(p, 0, {12'h0, 2'(p + m), 2'(m & 1), 3'(p), 1'b1,
                       12'(100 * p + m)});
        set_tag(p, 1, {12'h0, 2'(p + m + 1), 2'(~m & 1), 3'(m), 1'b0,
                       12'(7 * p)});
      end
      for (int p = 1; p <= 3; p++) begin
        frm(p, 1'b0, 4'hA, 7'h0, 3'(p + 2));
        frm(p, 1'b0, 4'hB, 7'h5, 3'h6);
        frm(p, 1'b1, 4'hC, 7'h9, 3'h1);
      end
      drain();
    end
    $display("test modes done");
  endtask

  task automatic t_bypass();
    frm(0, 1'b0, 4'h3, 7'h11, 3'h2);
    frm(0, 1'b1, 4'h4, 7'h0, 3'h5);
    drain();
    $display("test bypass done");
  endtask

  task automatic t_stream();
    int n;
    far.stall <= 1'b1;
    for (int i = 0; i < 12; i++)
      frm(i % 4, 1'(i / 6), 4'(i), 7'(i), 3'(i));
    n = 0;
    while (IN_READY !== 1'b0 && n < 50) begin
      @(posedge CLK);
      n++;
    end
    cmp_w(32'h1, 32'(n < 50));
    // Clock enable low must freeze the full queue and the held output
    CE <= 1'b0;
    repeat (5) @(posedge CLK);
    cmp_w(32'h0, {31'h0, IN_READY});
    cmp_w(32'h1, {31'h0, OUT_VALID});
    CE <= 1'b1;
    far.stall <= 1'b0;
    drain();
    repeat (3) @(posedge CLK);
    cmp_w(32'h2, {30'h0, IN_READY, OUT_VALID});
    $display("test stream done");
  endtask

  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    CLK = 1'b0;
    RST = 1'b1;
    CE = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    errors = 0;
    compares = 0;
    nmir = 0;
    for (int p = 1; p <= 3; p++) begin
      pport[p] = '0;
      penc[p] = '0;
      pmode[p] = '0;
      tcfg[p][0] = `MRW_TAG_RST;
      tcfg[p][1] = `MRW_TAG_RST;
    end
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    t_modes();
    t_bypass();
    t_stream();
    rd(`MRW_OFS_COUNT, 32'(nmir), `MRW_RESP_OKAY);
    close_out();
  end

  // Whole run needs a few hundred cycles; this allows twenty thousand
  initial begin
    #800us;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
endmodule
